/* cap_pkg.sv */
// Constants for the counter array block: register map, fields, modes.
// Assumes a plain register port with one-cycle strobes and 8-bit data.
// Functional notes
// - Select 00: count every system clock
// - Select 01: count every 4 clocks
// - Select 10: count every 12 clocks
// - Select 11: count external pin falling edges
// - Twelve-clock mode doubles each prescaler period
// - Rising edge capture copies counter
// - Falling edge capture copies counter
// - Both-edge capture copies counter on either
// - Capture, timer, toggle events share one interrupt
// - Timer mode flags on counter rollover
// - Toggle output inverts on counter match
// - Written toggle state one clears next match
// - 8-bit PWM uses low byte, 256 period
// - 8-bit PWM zero value holds pin low
// - 16-bit PWM uses full value, 65536 period
// - 16-bit PWM zero value holds pin low
// - Run bit cleared stops PWM, pin low
// - Mode codes: off, captures, timer, toggle, PWMs
// - Counter runs only while run bit set
// - Idle-stop bit gates counter during idle
// - Channel flags stay set until software clears
package cap_pkg;
    localparam int NCH = 5;
    localparam logic [7:0] ADDR_CTRL1 = 8'ha1;
    localparam logic [7:0] ADDR_CTRL2 = 8'ha2;
    localparam logic [7:0] ADDR_CNTH = 8'h9a;
    localparam logic [7:0] ADDR_CNTL = 8'h9b;
    localparam logic [7:0] ADDR_CHCON0 = 8'ha3;
    localparam logic [7:0] ADDR_DH [NCH] = '{8'h9c, 8'h9e, 8'h91, 8'h93,
        8'h95};
    localparam logic [7:0] ADDR_DL [NCH] = '{8'h9d, 8'h9f, 8'h92, 8'h94,
        8'h96};
    localparam int BIT_RUN = 7;
    localparam int BIT_IDLE_STOP = 6;
    localparam int BIT_TOGGLE = 4;
    localparam int BIT_SEL_LO = 6;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    typedef enum logic [1:0] {
        CLK_SYS = 2'b00,
        CLK_DIV4 = 2'b01,
        CLK_DIV12 = 2'b10,
        CLK_EXT = 2'b11
    } cap_clk_sel_t;
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_CAP_RISE = 3'b001,
        MODE_CAP_FALL = 3'b010,
        MODE_CAP_BOTH = 3'b011,
        MODE_TIMER = 3'b100,
        MODE_TOGGLE = 3'b101,
        MODE_PWM8 = 3'b110,
        MODE_PWM16 = 3'b111
    } cap_mode_t;
endpackage

/* cap_channel.sv */
// One compare/capture channel of the counter array.
// Assumes a synchronised pin and a one-cycle count enable from the top.
`timescale 1ns/1ps
`default_nettype none
module cap_channel (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire cap_pkg::cap_mode_t mode, // Channel mode
    input wire logic run, // Counter run bit
    input wire logic tick, // Counter advances this cycle
    input wire logic [15:0] count, // Current counter value
    input wire logic pinSync, // Synchronised channel pin
    input wire logic wrDh, // Write data high byte
    input wire logic wrDl, // Write data low byte
    input wire logic wrTog, // Write toggle state
    input wire logic [7:0] wdata, // Write data
    output logic [15:0] data_q, // Channel data value
    output logic toggle_q, // Toggle state
    output logic pinOut_q, // Channel pin drive
    output logic event_o // Channel function fired
);
    import cap_pkg::*;
    logic pinPrev_q;
    logic rise, fall, capture, match, rollover;
    assign rise = pinSync && !pinPrev_q;
    assign fall = !pinSync && pinPrev_q;
    assign capture = (mode == MODE_CAP_RISE && rise)
        || (mode == MODE_CAP_FALL && fall)
        || (mode == MODE_CAP_BOTH && (rise || fall));
    // Match is taken on the cycle the counter steps onto the value.
    assign match = tick && (count + 16'h0001 == data_q);
    assign rollover = tick && count == 16'hffff;
    assign event_o = capture || (mode == MODE_TIMER && rollover)
        || (mode == MODE_TOGGLE && match);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinPrev_q <= 1'b0;
        end else begin
            pinPrev_q <= pinSync;
        end
    end

    // Capture wins over a software write in the same cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_q <= 16'h0000;
        end else if (capture) begin
            data_q <= count;
        end else begin
            if (wrDh) begin
                data_q[15:8] <= wdata;
            end
            if (wrDl) begin
                data_q[7:0] <= wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            toggle_q <= 1'b0;
        end else if (mode == MODE_TOGGLE && match) begin
            toggle_q <= !toggle_q;
        end else if (wrTog) begin
            toggle_q <= wdata[BIT_TOGGLE];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinOut_q <= 1'b0;
        end else begin
            unique case (mode)
                MODE_TOGGLE: begin
                    pinOut_q <= (match ? !toggle_q : toggle_q);
                end
                MODE_PWM8: begin
                    pinOut_q <= run && count[7:0] < data_q[7:0];
                end
                MODE_PWM16: begin
                    pinOut_q <= run && count < data_q;
                end
                default: begin
                    pinOut_q <= 1'b0;
                end
            endcase
        end
    end
endmodule // cap_channel
`default_nettype wire

/* cap_counter_array.sv */
// Top of the counter array: time base, prescaler, registers, channels.
// Assumes a plain register port; pins arrive asynchronously.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cap_counter_array (
    input wire logic clk, // System clock, 200 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [7:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Register write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [7:0] regRdata_q, // Read data, cycle after strobe
    input wire logic idleMode, // Processor idle mode
    input wire logic twelveClockCycleMode, // Processor machine-cycle mode
    input wire logic extCountClockPin, // External count clock pin
    input wire logic [cap_pkg::NCH-1:0] channelPinIn, // Channel pins in
    output logic [cap_pkg::NCH-1:0] channelPinOut_q, // Channel pins out
    output logic [cap_pkg::NCH-1:0] channelPinOe_q, // Channel pin enable
    output logic irq_q // Shared interrupt request
);
    import cap_pkg::*;
    logic counterRun_q, idleCounterStop_q;
    logic [NCH-1:0] irqEnable_q, irqFlag_q;
    logic [1:0] clkSel_q;
    logic [15:0] count_q;
    logic [3:0] preDiv_q;
    logic halfGate_q;
    logic [2:0] extSync_q;
    logic [NCH-1:0] pinMeta_q, pinSync_q;
    cap_mode_t chMode_q [NCH];
    logic [15:0] chData [NCH];
    logic [NCH-1:0] chTog, chPin, chEvent;
    logic counting, divDone, tick;
    logic [3:0] divLast;

    // Machine-cycle mode and the pin the channel drives are loose bits.
    assign counting = counterRun_q && !(idleCounterStop_q && idleMode);
    always_comb begin
        divLast = 4'h0;
        unique case (cap_clk_sel_t'(clkSel_q))
            CLK_SYS: divLast = 4'h0;
            CLK_DIV4: divLast = DIV4_LAST;
            CLK_DIV12: divLast = DIV12_LAST;
            CLK_EXT: divLast = 4'h0;
        endcase
    end
    assign divDone = (preDiv_q == divLast)
        && (!twelveClockCycleMode || halfGate_q);
    assign tick = counting && (cap_clk_sel_t'(clkSel_q) == CLK_EXT
        ? (extSync_q[2] && !extSync_q[1]) : divDone);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            preDiv_q <= 4'h0;
            halfGate_q <= 1'b0;
        end else if (!counting) begin
            preDiv_q <= 4'h0;
            halfGate_q <= 1'b0;
        end else if (preDiv_q == divLast) begin
            preDiv_q <= 4'h0;
            halfGate_q <= twelveClockCycleMode && !halfGate_q;
        end else begin
            preDiv_q <= preDiv_q + 4'h1;
        end
    end

    // Stage 0 feeds only stage 1; the edge is seen between 1 and 2.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extSync_q <= 3'b000;
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            extSync_q <= {extSync_q[1:0], extCountClockPin};
            pinMeta_q <= channelPinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return regWr && a == b;
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q <= 16'h0000;
        end else if (hit(regAddr, ADDR_CNTH)) begin
            count_q[15:8] <= regWdata;
        end else if (hit(regAddr, ADDR_CNTL)) begin
            count_q[7:0] <= regWdata;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counterRun_q <= 1'b0;
            idleCounterStop_q <= 1'b0;
            irqEnable_q <= '0;
        end else if (hit(regAddr, ADDR_CTRL1)) begin
            counterRun_q <= regWdata[BIT_RUN];
            idleCounterStop_q <= regWdata[BIT_IDLE_STOP];
            irqEnable_q <= regWdata[NCH-1:0];
        end
    end

    // Hardware set beats a software clear in the same cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkSel_q <= 2'b00;
            irqFlag_q <= '0;
        end else begin
            if (hit(regAddr, ADDR_CTRL2)) begin
                clkSel_q <= regWdata[BIT_SEL_LO +: 2];
                irqFlag_q <= regWdata[NCH-1:0] | chEvent;
            end else begin
                irqFlag_q <= irqFlag_q | chEvent;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irqFlag_q & irqEnable_q);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gCh
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    chMode_q[g] <= MODE_OFF;
                end else if (hit(regAddr, ADDR_CHCON0 + 8'(g))) begin
                    chMode_q[g] <= cap_mode_t'(regWdata[2:0]);
                end
            end
            cap_channel uCh (
                .clk(clk),
                .sys_rst(sys_rst),
                .mode(chMode_q[g]),
                .run(counterRun_q),
                .tick(tick),
                .count(count_q),
                .pinSync(pinSync_q[g]),
                .wrDh(hit(regAddr, ADDR_DH[g])),
                .wrDl(hit(regAddr, ADDR_DL[g])),
                .wrTog(hit(regAddr, ADDR_CHCON0 + 8'(g))),
                .wdata(regWdata),
                .data_q(chData[g]),
                .toggle_q(chTog[g]),
                .pinOut_q(chPin[g]),
                .event_o(chEvent[g])
            );
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    channelPinOut_q[g] <= 1'b0;
                    channelPinOe_q[g] <= 1'b0;
                end else begin
                    channelPinOut_q[g] <= chPin[g];
                    channelPinOe_q[g] <= chMode_q[g] == MODE_TOGGLE
                        || chMode_q[g] == MODE_PWM8
                        || chMode_q[g] == MODE_PWM16;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdata_q <= RESET_VAL;
        end else if (regRd) begin
            regRdata_q <= RESET_VAL;
            if (regAddr == ADDR_CTRL1) begin
                regRdata_q <= {counterRun_q, idleCounterStop_q, 1'b0,
                    irqEnable_q};
            end
            if (regAddr == ADDR_CTRL2) begin
                regRdata_q <= {clkSel_q, 1'b0, irqFlag_q};
            end
            if (regAddr == ADDR_CNTH) begin
                regRdata_q <= count_q[15:8];
            end
            if (regAddr == ADDR_CNTL) begin
                regRdata_q <= count_q[7:0];
            end
            for (int i = 0; i < NCH; i++) begin
                if (regAddr == ADDR_CHCON0 + 8'(i)) begin
                    regRdata_q <= {3'b000, chTog[i], 1'b0, chMode_q[i]};
                end
                if (regAddr == ADDR_DH[i]) begin
                    regRdata_q <= chData[i][15:8];
                end
                if (regAddr == ADDR_DL[i]) begin
                    regRdata_q <= chData[i][7:0];
                end
            end
        end else begin
            regRdata_q <= RESET_VAL;
        end
    end
endmodule // cap_counter_array
`default_nettype wire

/* cap_properties.sv */
// Checker for the counter array top: readback, pin enable, PWM, irq.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cap_properties (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic [7:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [7:0] regRdata_q, // Read data
    input wire logic [cap_pkg::NCH-1:0] channelPinIn, // Pins in
    input wire logic [cap_pkg::NCH-1:0] channelPinOut_q, // Pins out
    input wire logic [cap_pkg::NCH-1:0] channelPinOe_q, // Pin enable
    input wire logic irq_q // Interrupt request
);
    import cap_pkg::*;
    logic [7:0] ctl_q;
    logic [1:0] sel_q;
    logic [2:0] mode_q;
    logic [15:0] dat_q;
    logic ctlWr;
    assign ctlWr = regWr && (regAddr == ADDR_CTRL1 || regAddr == ADDR_CTRL2);
    // Shadows follow software writes only, so channel 0 data is blind to
    // captures; PWM checks rely on data being rewritten first.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_q <= 8'h00;
            sel_q <= 2'h0;
            mode_q <= 3'h0;
            dat_q <= 16'h0000;
        end else if (regWr) begin
            if (regAddr == ADDR_CTRL1) ctl_q <= regWdata & 8'hdf;
            if (regAddr == ADDR_CTRL2) sel_q <= regWdata[7:6];
            if (regAddr == ADDR_CHCON0) mode_q <= regWdata[2:0];
            if (regAddr == ADDR_DH[0]) dat_q[15:8] <= regWdata;
            if (regAddr == ADDR_DL[0]) dat_q[7:0] <= regWdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ctl_read_a: assert property (
        $past(regRd) && $past(regAddr) == ADDR_CTRL1 |-> regRdata_q == ctl_q)
        else $error("control 1 readback wrong");
    sel_read_a: assert property (
        $past(regRd) && $past(regAddr) == ADDR_CTRL2
        |-> regRdata_q[7:5] == {sel_q, 1'b0}) else $error("select readback");
    oe_mode_a: assert property (
        $stable(mode_q) |-> channelPinOe_q[0] == (mode_q >= MODE_TOGGLE))
        else $error("pin enable does not follow mode");
    // The shadows move with the write; the pin lags it by two registers.
    pwm_stop_a: assert property (
        mode_q[2:1] == 2'b11 && !ctl_q[7] |=> ##1 !channelPinOut_q[0])
        else $error("PWM pin high with run bit clear");
    pwm_zero_a: assert property (
        (mode_q == MODE_PWM8 && dat_q[7:0] == 8'h00) ||
        (mode_q == MODE_PWM16 && dat_q == 16'h0000)
        |=> ##1 !channelPinOut_q[0])
        else $error("PWM pin high with zero value");
    irq_en_a: assert property (
        irq_q |-> ($past(ctl_q[4:0]) | ctl_q[4:0]) != 5'h00)
        else $error("irq without any enable");
    irq_hold_a: assert property (
        $fell(irq_q) |-> $past(ctlWr) || $past(ctlWr, 2))
        else $error("irq dropped without software write");
    cap_irq_a: assert property (
        mode_q == MODE_CAP_RISE && ctl_q[0] && $rose(channelPinIn[0])
        |-> ##[1:8] irq_q) else $error("capture raised no irq");
    cover property ($rose(irq_q));
    cover property ($rose(channelPinOut_q[0]));
    cover property ($fell(channelPinOut_q[3]));
endmodule // cap_properties
bind cap_counter_array cap_properties u_cap_properties (.clk(clk),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
    .channelPinIn(channelPinIn), .channelPinOut_q(channelPinOut_q),
    .channelPinOe_q(channelPinOe_q), .irq_q(irq_q));
`default_nettype wire

/* cap_pin_model.sv */
// Far-side pin model: external count clock source and channel inputs.
// Assumes callers enter its tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cap_pin_model (
    input wire logic clk, // System clock
    output logic extClk, // External count clock pin
    output logic [cap_pkg::NCH-1:0] chanPins // Channel input pins
);
    import cap_pkg::*;
    initial begin
        extClk = 1'b1;
        chanPins = '0;
    end
    // Half periods below four clocks would exceed one eighth of the clock.
    task automatic ext_pulses(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge clk);
            extClk <= 1'b0;
            repeat (half) @(posedge clk);
            extClk <= 1'b1;
        end
    endtask
    task automatic chan_set(input logic [NCH-1:0] v);
        @(posedge clk);
        chanPins <= v;
    endtask
endmodule // cap_pin_model
`default_nettype wire

/* cap_counter_array_tb.sv */
// Self-checking bench for the counter array with a read scoreboard.
// Assumes the checker file binds itself to the top module.
`timescale 1ns/1ps
`default_nettype none
module cap_counter_array_tb;
    import cap_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic idleMode = 1'b0;
    logic twelveClockCycleMode = 1'b0;
    logic rdSeen = 1'b0;
    logic extClk, irq;
    logic [NCH-1:0] pinIn, pinOut;
    logic [7:0] rdata;
    logic [15:0] expQ[$];
    int n_fail = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    cap_counter_array u_cap_counter_array (.clk(clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata_q(rdata), .idleMode(idleMode),
        .twelveClockCycleMode(twelveClockCycleMode), .extCountClockPin(extClk),
        .channelPinIn(pinIn), .channelPinOut_q(pinOut),
        .channelPinOe_q(), .irq_q(irq));
    cap_pin_model u_cap_pin_model (.clk(clk), .extClk(extClk), .chanPins(pinIn));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // Each read notes a mask and the expected byte for the monitor.
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back({m, e});
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    always @(posedge clk) begin
        rdSeen <= regRd;
        if (rdSeen) begin
            check({8'h00, rdata & expQ[0][15:8]}, {8'h00, expQ[0][7:0]});
            void'(expQ.pop_front());
        end
    end
    task automatic cnt(input logic [15:0] v);
        wr(ADDR_CNTH, v[15:8]);
        wr(ADDR_CNTL, v[7:0]);
    endtask
    // Run stays set for exactly m cycles between the two write edges.
    task automatic run_for(input logic [7:0] c, input int m);
        wr(ADDR_CTRL1, c);
        repeat (m - 2) @(posedge clk);
        wr(ADDR_CTRL1, c & 8'h7f);
    endtask
    task automatic wait_irq(input logic v);
        int k = 0;
        while (irq !== v && k < 8) begin
            @(posedge clk);
            k++;
        end
        check({15'h0, irq}, {15'h0, v});
    endtask
    task automatic pwm(input logic [7:0] md, input logic [15:0] v,
        input logic [15:0] s, input logic [15:0] e);
        int hi = 0;
        wr(ADDR_DH[0], v[15:8]);
        wr(ADDR_DL[0], v[7:0]);
        wr(ADDR_CHCON0, md);
        cnt(s);
        wr(ADDR_CTRL1, 8'h80);
        repeat (256) begin
            @(posedge clk);
            hi += int'(pinOut[0] === 1'b1);
        end
        check(hi[15:0], e);
        wr(ADDR_CTRL1, 8'h00);
        repeat (3) @(posedge clk);
        check({15'h0, pinOut[0]}, 16'h0000);
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        logic [15:0] a, b;
        static int ex[8] = '{24, 6, 2, 12, 3, 1, 0, 24};
        static logic [7:0] ad[8] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_CNTH, ADDR_CNTL,
            ADDR_CHCON0, ADDR_DH[4], ADDR_DL[4], 8'h00};
        void'($urandom(32'hb47c));
        a = 16'($urandom);
        b = 16'($urandom);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ad[i]) rd(ad[i], 8'hff, 8'h00);
        for (int i = 0; i < 8; i++) begin
            twelveClockCycleMode <= (i inside {[3:5]});
            idleMode <= (i > 5);
            wr(ADDR_CTRL2, (i < 6) ? 8'((i % 3) << 6) : 8'h00);
            cnt(a);
            run_for((i == 6) ? 8'hc0 : 8'h80, 24);
            rd(ADDR_CNTL, 8'hff, 8'(a + ex[i]));
            rd(ADDR_CNTH, 8'hff, 8'((a + ex[i]) >> 8));
        end
        idleMode <= 1'b0;
        twelveClockCycleMode <= 1'b0;
        wr(ADDR_CTRL2, 8'hc0);
        cnt(b);
        wr(ADDR_CTRL1, 8'h80);
        u_cap_pin_model.ext_pulses(5, 4);
        repeat (4) @(posedge clk);
        wr(ADDR_CTRL1, 8'h1f);
        rd(ADDR_CNTL, 8'hff, 8'(b + 16'h5));
        for (int m = 1; m < 4; m++) wr(ADDR_CHCON0 + 8'(m - 1), 8'(m));
        cnt(a);
        u_cap_pin_model.chan_set(5'h07);
        repeat (8) @(posedge clk);
        for (int c = 0; c < 3; c++) rd(ADDR_DL[c], 8'hff, c == 1 ? 8'h00 : a[7:0]);
        cnt(b);
        u_cap_pin_model.chan_set(5'h00);
        repeat (8) @(posedge clk);
        for (int c = 0; c < 3; c++) rd(ADDR_DL[c], 8'hff, c == 0 ? a[7:0] : b[7:0]);
        rd(ADDR_CTRL2, 8'h1f, 8'h07);
        wait_irq(1'b1);
        wr(ADDR_CTRL1, 8'h00);
        wait_irq(1'b0);
        wr(ADDR_CTRL1, 8'h01);
        wait_irq(1'b1);
        wr(ADDR_CTRL2, 8'h00);
        wait_irq(1'b0);
        wr(ADDR_DH[3], 8'h12);
        wr(ADDR_DL[3], 8'h34);
        wr(ADDR_CHCON0 + 8'h3, 8'h05);
        // The third pass sets the toggle state while it is low, so only a
        // working software override can bring the pin low at that match.
        for (int t = 0; t < 3; t++) begin
            if (t == 2) wr(ADDR_CHCON0 + 8'h3, 8'h15);
            cnt(16'h1230);
            run_for(8'h80, 12);
            check({15'h0, pinOut[3]}, {15'h0, 1'(t == 0)});
        end
        wr(ADDR_CTRL2, 8'h00);
        wr(ADDR_CHCON0 + 8'h4, 8'h04);
        cnt(16'hfff0);
        run_for(8'h90, 24);
        rd(ADDR_CTRL2, 8'h1f, 8'h10);
        wait_irq(1'b1);
        pwm(8'h06, 16'hff00, 16'h0000, 16'h0000);
        pwm(8'h06, 16'hff40, 16'h0000, 16'h0040);
        pwm(8'h07, 16'h0000, 16'h0000, 16'h0000);
        pwm(8'h07, 16'h0100, 16'h00f0, 16'h0010);
        test_done;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        test_done;
    end
endmodule // cap_counter_array_tb
`default_nettype wire
